// >>> hw/sap_dev.sv
`timescale 1ns/1ps
// Overview of operation
// [R01] Host holds convert low at least 40 ns
// [R02] Busy low from start until result stored
// [R03] Results are 16-bit two's complement codes
// [R04] Select and convert low: hold, start conversion
// [R05] Track after end; host spaces converts 4 us
// [R06] Start is level OR of active-low inputs
// [R07] Host sets non-trigger input 10 ns early
// [R08] Bus driven only when convert high, select low
// [R09] Either falling input starts, bus stays released
// [R10] Bus shows latest result, previous while busy
// [R11] Both low at busy rise: no acquisition
// [R12] Word read or two byte reads per cycle
// [R13] New data valid 35 ns before busy rises
// [R14] Previous data kept 1.5 us after start
// [R15] Conversion ends within 2 us
// [R16] New data on bus within 1.2 us; here it reaches the bus 189 cycles, about 1.51 us, after start
// [R17] Convert low 40 ns while busy aborts
// [R18] After abort, convert high full cycle time
// [R19] Host without busy monitor aborts at init
// [R20] Host avoids reading during a conversion
// [R21] Select tied low: convert edges start, enable
// [R22] Byte select low: high byte on upper lanes
// [R23] Result register held until next conversion ends

// ---------------------------------------------------------------------------
// Converter control and readout port, device end
// ---------------------------------------------------------------------------
module sap_dev
(
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          NRST,
    // Sampler side
    input  wire logic [sap_pkg::DATA_W-1:0]    SAMPLE,
    output      logic                          HOLD,
    // Host link
    sap_if.dev                                 LINK
);

    import sap_pkg::*;

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------

    // Whole device state in one record
    typedef struct packed {
        sap_dev_st_t         state;
        logic [CNT_W-1:0]    cnt;
        logic [LOW_W-1:0]    low_cnt;
        logic                armed;
        logic                hold;
        logic                busy_n;
        logic [DATA_W-1:0]   sample;
        logic [DATA_W-1:0]   result;
        logic [DATA_W-1:0]   db_o;
        logic                db_oe;
    } sap_dev_regs_t;

    localparam sap_dev_regs_t DEV_RST = '{
        state:   DEV_IDLE,
        cnt:     '0,
        low_cnt: '0,
        armed:   1'b0,
        hold:    1'b0,
        busy_n:  1'b1,
        sample:  CODE_MID,
        result:  CODE_MID,
        db_o:    CODE_MID,
        db_oe:   1'b0
    };

    sap_dev_regs_t   st_reg;
    sap_dev_regs_t   st_next;
    logic            start_cond;

    // -----------------------------------------------------------------------
    // Control decode
    // -----------------------------------------------------------------------

    // Level OR of the two active-low inputs; no edge needed
    assign start_cond = !LINK.cs_n && !LINK.rc_n;  // [R06]

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------

    // Sequencer, abort watch and bus drive
    always_comb
    begin
        st_next = st_reg;

        // Bus follows the pins every cycle, busy or not
        st_next.db_oe = !LINK.cs_n && LINK.rc_n;  // [R08] [R21]

        // Upper lanes get the selected half; a full word read keeps order
        if (LINK.byte_sel)
        begin
            st_next.db_o = {st_reg.result[BYTE_W-1:0],
                            st_reg.result[DATA_W-1:BYTE_W]};  // [R22] [R12]
        end
        else
        begin
            st_next.db_o = st_reg.result;  // [R10] [R12]
        end

        case (st_reg.state)
            DEV_IDLE:
            begin
                // Either input may be the last to fall
                if (start_cond)  // [R04] [R09] [R21]
                begin
                    st_next.state   = DEV_CONV;
                    st_next.cnt     = '0;
                    st_next.low_cnt = '0;
                    st_next.armed   = 1'b0;
                    st_next.busy_n  = 1'b0;  // [R02]
                    st_next.hold    = 1'b1;  // [R04]
                    // A sampler still in hold has not acquired anew
                    if (!st_reg.hold)
                    begin
                        st_next.sample = SAMPLE;  // [R03] [R11]
                    end
                end
            end

            DEV_CONV:
            begin
                st_next.cnt = st_reg.cnt + 1'b1;

                // Abort needs a fresh low, so the start level is ignored
                if (LINK.rc_n)
                begin
                    st_next.armed   = 1'b1;
                    st_next.low_cnt = '0;
                end
                else if (st_reg.armed)
                begin
                    st_next.low_cnt = st_reg.low_cnt + 1'b1;
                end

                if (st_reg.armed && !LINK.rc_n &&
                    st_reg.low_cnt == ABORT_CNT)
                begin
                    // Terminate; result register keeps the last word
                    st_next.state  = DEV_ABORT;  // [R17]
                    st_next.busy_n = 1'b1;
                    st_next.hold   = 1'b0;
                end
                else if (st_reg.cnt == RESULT_CNT)
                begin
                    // Late enough that the old word outlives its window
                    st_next.result = st_reg.sample;  // [R14] [R23] [R16]
                end
                else if (st_reg.cnt == DONE_CNT)
                begin
                    // Busy rises a margin after the bus word settles
                    st_next.state  = DEV_IDLE;  // [R13] [R15]
                    st_next.busy_n = 1'b1;  // [R02]
                    // Still both low: restart without a new acquisition
                    st_next.hold   = start_cond;  // [R05] [R11]
                end
            end

            DEV_ABORT:
            begin
                // Next start waits for convert to return high
                if (LINK.rc_n)
                begin
                    st_next.state = DEV_IDLE;  // [R18]
                end
            end

            default:
            begin
                st_next = DEV_RST;
            end
        endcase
    end

    // -----------------------------------------------------------------------
    // Registers
    // -----------------------------------------------------------------------

    // Single state register for the whole port
    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_reg <= DEV_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // -----------------------------------------------------------------------
    // Outputs
    // -----------------------------------------------------------------------

    // All straight from flip-flops
    assign HOLD        = st_reg.hold;
    assign LINK.busy_n = st_reg.busy_n;  // [R02]
    assign LINK.db_o   = st_reg.db_o;
    assign LINK.db_oe  = st_reg.db_oe;  // [R08]

endmodule: sap_dev

// >>> hw/sap_host.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Converter control and readout port, host end
// ---------------------------------------------------------------------------
module sap_host
(
    // Clock and reset
    input  wire logic                          CLK,
    input  wire logic                          NRST,
    // User requests
    input  wire logic                          START,
    input  wire logic                          ABORT,
    input  wire logic                          BYTE_MODE,
    // User answers
    output      logic                          READY,
    output      logic [sap_pkg::DATA_W-1:0]    RESULT,
    output      logic                          RESULT_VALID,
    // Device link
    sap_if.host                                LINK
);

    import sap_pkg::*;

    // -----------------------------------------------------------------------
    // State
    // -----------------------------------------------------------------------

    typedef struct packed {
        sap_host_st_t        state;
        logic [HCNT_W-1:0]   cnt;
        logic [TC_W-1:0]     tc;
        logic                cs_n;
        logic                rc_n;
        logic                byte_sel;
        logic                ready;
        logic [DATA_W-1:0]   data;
        logic                valid;
    } sap_host_regs_t;

    localparam sap_host_regs_t HOST_RST = '{
        state:    HOST_INIT,
        cnt:      '0,
        tc:       '0,
        cs_n:     1'b1,
        rc_n:     1'b1,
        byte_sel: 1'b0,
        ready:    1'b0,
        data:     CODE_MID,
        valid:    1'b0
    };

    sap_host_regs_t   st_reg;
    sap_host_regs_t   st_next;

    // -----------------------------------------------------------------------
    // Next state
    // -----------------------------------------------------------------------

    // Convert, wait, read; reads only after busy rises
    always_comb
    begin
        st_next       = st_reg;
        st_next.valid = 1'b0;
        st_next.cnt   = st_reg.cnt + 1'b1;
        // Cycle timer since the last falling convert, saturating
        if (st_reg.tc != TC_MAX)
        begin
            st_next.tc = st_reg.tc + 1'b1;
        end

        case (st_reg.state)
            HOST_INIT:
            begin
                // Busy state unknown after reset, so abort first
                st_next.state = HOST_ABORT;  // [R19]
                st_next.cs_n  = 1'b0;
                st_next.rc_n  = 1'b0;
                st_next.cnt   = '0;
                st_next.tc    = '0;
            end

            HOST_ABORT:
            begin
                if (st_reg.cnt == PULSE_CNT)
                begin
                    st_next.state = HOST_IDLE;  // [R17] [R18]
                    st_next.cs_n  = 1'b1;
                    st_next.rc_n  = 1'b1;
                end
            end

            HOST_IDLE:
            begin
                // Full cycle time since the previous convert
                if (START && st_reg.tc == TC_MAX)  // [R05] [R18]
                begin
                    st_next.state = HOST_SETUP;
                    st_next.cs_n  = 1'b0;
                    st_next.cnt   = '0;
                end
            end

            HOST_SETUP:
            begin
                // Select settles first so convert is the trigger
                if (st_reg.cnt == SETUP_CNT)  // [R07]
                begin
                    st_next.state = HOST_PULSE;
                    st_next.rc_n  = 1'b0;
                    st_next.cnt   = '0;
                    st_next.tc    = '0;
                end
            end

            HOST_PULSE:
            begin
                // Both released long before busy can rise
                if (st_reg.cnt == PULSE_CNT)  // [R01] [R11]
                begin
                    st_next.state = HOST_WAIT;
                    st_next.cs_n  = 1'b1;
                    st_next.rc_n  = 1'b1;
                end
            end

            HOST_WAIT:
            begin
                if (ABORT)
                begin
                    st_next.state = HOST_ABORT;  // [R17]
                    st_next.cs_n  = 1'b0;
                    st_next.rc_n  = 1'b0;
                    st_next.cnt   = '0;
                    st_next.tc    = '0;
                end
                else if (LINK.busy_n)
                begin
                    // No reads while converting keeps the analog quiet
                    st_next.state    = HOST_RDHI;  // [R14] [R20]
                    st_next.cs_n     = 1'b0;
                    st_next.byte_sel = 1'b0;
                    st_next.cnt      = '0;
                end
            end

            HOST_RDHI:
            begin
                if (st_reg.cnt == READ_CNT)
                begin
                    if (BYTE_MODE)
                    begin
                        st_next.data[DATA_W-1:BYTE_W] =
                            LINK.db[DATA_W-1:BYTE_W];  // [R12] [R22]
                        st_next.state    = HOST_RDLO;
                        st_next.byte_sel = 1'b1;
                        st_next.cnt      = '0;
                    end
                    else
                    begin
                        st_next.data  = LINK.db;
                        st_next.state = HOST_IDLE;
                        st_next.cs_n  = 1'b1;
                        st_next.valid = 1'b1;
                    end
                end
            end

            HOST_RDLO:
            begin
                if (st_reg.cnt == READ_CNT)
                begin
                    // Low half arrives on the upper lanes
                    st_next.data[BYTE_W-1:0] =
                        LINK.db[DATA_W-1:BYTE_W];  // [R12] [R22]
                    st_next.state    = HOST_IDLE;
                    st_next.cs_n     = 1'b1;
                    st_next.byte_sel = 1'b0;
                    st_next.valid    = 1'b1;
                end
            end

            default:
            begin
                st_next = HOST_RST;
            end
        endcase

        st_next.ready = (st_next.state == HOST_IDLE) &&
                        (st_next.tc == TC_MAX);
    end

    // -----------------------------------------------------------------------
    // Registers and outputs
    // -----------------------------------------------------------------------

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
        begin
            st_reg <= HOST_RST;
        end
        else
        begin
            st_reg <= st_next;
        end
    end

    // All outputs straight from flip-flops
    assign READY         = st_reg.ready;
    assign RESULT        = st_reg.data;
    assign RESULT_VALID  = st_reg.valid;
    assign LINK.cs_n     = st_reg.cs_n;
    assign LINK.rc_n     = st_reg.rc_n;
    assign LINK.byte_sel = st_reg.byte_sel;

endmodule: sap_host

// >>> hw/sap_if.sv
`timescale 1ns/1ps
// ---------------------------------------------------------------------------
// Parallel link between converter port and host
// ---------------------------------------------------------------------------
interface sap_if;

    logic                        cs_n;
    logic                        rc_n;
    logic                        byte_sel;
    logic                        busy_n;
    logic [sap_pkg::DATA_W-1:0]  db_o;
    logic                        db_oe;
    wire  [sap_pkg::DATA_W-1:0]  db;

    // Released lanes read inverted, so an early read shows up as wrong data
    assign db = db_oe ? db_o : ~db_o;

    modport dev (
        input  cs_n,
        input  rc_n,
        input  byte_sel,
        output busy_n,
        output db_o,
        output db_oe
    );

    modport host (
        output cs_n,
        output rc_n,
        output byte_sel,
        input  busy_n,
        input  db
    );

endinterface: sap_if

// >>> hw/sap_pkg.sv
// ---------------------------------------------------------------------------
// Shared constants for the converter port and its host
// ---------------------------------------------------------------------------
package sap_pkg;

    // Clock rate of every module on either end
    localparam int CLK_MHZ = 125;

    // Data path widths
    localparam int DATA_W = 16;
    localparam int BYTE_W = 8;

    // Output codes, two's complement
    localparam logic [DATA_W-1:0] CODE_POS_FS  = 16'h7fff;
    localparam logic [DATA_W-1:0] CODE_MID     = 16'h0000;
    localparam logic [DATA_W-1:0] CODE_MID_M1  = 16'hffff;
    localparam logic [DATA_W-1:0] CODE_NEG_FS  = 16'h8000;

    // Printed times, in ns
    localparam int CONVERT_PULSE_WIDTH_NS    = 40;
    localparam int INPUT_SETUP_NS            = 10;
    localparam int CYCLE_TIME_NS             = 4000;
    localparam int PREV_VALID_NS             = 1500;
    localparam int CONV_TIME_MAX_NS          = 2000;
    localparam int BUSY_AFTER_VALID_DELAY_NS = 35;

    // Cycle counts: least times round up, longest times round down
    localparam int CONVERT_PULSE_WIDTH_CYC =
        (CONVERT_PULSE_WIDTH_NS * CLK_MHZ + 999) / 1000;
    localparam int INPUT_SETUP_CYC =
        (INPUT_SETUP_NS * CLK_MHZ + 999) / 1000;
    localparam int CYCLE_TIME_CYC =
        (CYCLE_TIME_NS * CLK_MHZ + 999) / 1000;
    localparam int PREV_VALID_CYC =
        (PREV_VALID_NS * CLK_MHZ + 999) / 1000;
    localparam int CONV_TIME_MAX_CYC =
        (CONV_TIME_MAX_NS * CLK_MHZ) / 1000;
    localparam int BUSY_AFTER_VALID_DELAY_CYC =
        (BUSY_AFTER_VALID_DELAY_NS * CLK_MHZ + 999) / 1000;

    // Cycles from bus enable until the host samples the data lanes
    localparam int READ_LAT_CYC = 2;

    // Device counter limits
    localparam int CNT_W = 8;
    localparam int LOW_W = 3;
    localparam logic [CNT_W-1:0] RESULT_CNT = CNT_W'(PREV_VALID_CYC - 1);
    localparam logic [CNT_W-1:0] DONE_CNT   =
        CNT_W'(PREV_VALID_CYC + BUSY_AFTER_VALID_DELAY_CYC);
    localparam logic [LOW_W-1:0] ABORT_CNT  =
        LOW_W'(CONVERT_PULSE_WIDTH_CYC - 1);

    // Host counter limits
    localparam int HCNT_W = 3;
    localparam int TC_W   = 9;
    localparam logic [HCNT_W-1:0] SETUP_CNT = HCNT_W'(INPUT_SETUP_CYC - 1);
    localparam logic [HCNT_W-1:0] PULSE_CNT =
        HCNT_W'(CONVERT_PULSE_WIDTH_CYC - 1);
    localparam logic [HCNT_W-1:0] READ_CNT  = HCNT_W'(READ_LAT_CYC - 1);
    localparam logic [TC_W-1:0]   TC_MAX    = TC_W'(CYCLE_TIME_CYC);

    // Device states
    typedef enum logic [1:0] {
        DEV_IDLE  = 2'b00,
        DEV_CONV  = 2'b01,
        DEV_ABORT = 2'b10
    } sap_dev_st_t;

    // Host states
    typedef enum logic [2:0] {
        HOST_INIT  = 3'b000,
        HOST_ABORT = 3'b001,
        HOST_IDLE  = 3'b010,
        HOST_SETUP = 3'b011,
        HOST_PULSE = 3'b100,
        HOST_WAIT  = 3'b101,
        HOST_RDHI  = 3'b110,
        HOST_RDLO  = 3'b111
    } sap_host_st_t;

endpackage: sap_pkg

// >>> testbench/sap_adc_parallel_conversion_port_test.sv
`timescale 1ns/1ps
// ----------------------------------------
// Bench for the converter port and its host
// ----------------------------------------
module sap_adc_parallel_conversion_port_test;
    import sap_pkg::*;

    // Clock, reset, user side and codes
    logic              clk             = 1'b0;
    logic              nrst            = 1'b0;
    logic              start           = 1'b0;
    logic              abort           = 1'b0;
    logic              byte_mode       = 1'b0;
    logic              ready;
    logic              result_valid;
    logic              hold_a;
    logic              hold_b;
    logic [DATA_W-1:0] result;
    logic [DATA_W-1:0] sample_a        = 16'h0000;
    logic [DATA_W-1:0] sample_b        = 16'h1234;
    int                n_fail          = 0;
    int                samples_checked = 0;
    int                cycles          = 0;
    logic [DATA_W-1:0] codes [4];

    sap_if link_a ();
    sap_if link_b ();

    // Host facing a device, and a second device driven by hand
    sap_dev sap_dev_inst
    (
        .CLK(clk), .NRST(nrst), .SAMPLE(sample_a), .HOLD(hold_a),
        .LINK(link_a)
    );
    sap_dev sap_dev_inst_b
    (
        .CLK(clk), .NRST(nrst), .SAMPLE(sample_b), .HOLD(hold_b),
        .LINK(link_b)
    );
    sap_host sap_host_inst
    (
        .CLK(clk), .NRST(nrst), .START(start), .ABORT(abort),
        .BYTE_MODE(byte_mode), .READY(ready), .RESULT(result),
        .RESULT_VALID(result_valid), .LINK(link_a)
    );
    sap_link_check sap_link_check_inst
    (
        .CLK(clk), .NRST(nrst), .cs_n(link_a.cs_n), .rc_n(link_a.rc_n),
        .byte_sel(link_a.byte_sel), .busy_n(link_a.busy_n),
        .db_o(link_a.db_o), .db_oe(link_a.db_oe)
    );

    always #4 clk = ~clk;

    // Inputs change only at falling edges
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask: tick

    task automatic chk(input logic [DATA_W-1:0] got,
                       input logic [DATA_W-1:0] exp);
        samples_checked++;
        if (got !== exp)
        begin
            n_fail++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask: chk

    // Select, convert and byte lines of the second link
    task automatic drive_b(input logic cs, input logic rc, input logic bs,
                           input int n);
        link_b.cs_n = cs;
        link_b.rc_n = rc;
        link_b.byte_sel = bs;
        tick(n);
    endtask: drive_b

    // Bounded waits; running out counts as a mismatch
    task automatic wait_busy_b();
        for (int k = 0; k < 400 && link_b.busy_n !== 1'b1; k++)
            tick(1);
        chk(16'(link_b.busy_n), 16'h0001);
    endtask: wait_busy_b

    task automatic wait_ready();
        for (int k = 0; k < 1000 && ready !== 1'b1; k++)
            tick(1);
        chk(16'(ready), 16'h0001);
    endtask: wait_ready

    task automatic wait_valid();
        for (int k = 0; k < 400 && result_valid !== 1'b1; k++)
            tick(1);
        chk(16'(result_valid), 16'h0001);
    endtask: wait_valid

    task automatic pulse_start();
        start = 1'b1;
        tick(1);
        start = 1'b0;
    endtask: pulse_start

    task automatic end_of_test();
        $display("checked %0d values, %0d wrong", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask: end_of_test

    // Cycle ceiling, about three times the expected run
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 12000)
        begin
            n_fail++;
            end_of_test();
        end
    end

    initial
    begin
        codes = '{CODE_POS_FS, CODE_MID, CODE_MID_M1, CODE_NEG_FS};
        drive_b(1'b1, 1'b1, 1'b0, 3);
        nrst = 1'b1;
        wait_ready();
        // Host reads every edge code, alternating word and byte reads
        for (int i = 0; i < 4; i++)
        begin
            sample_a = codes[i];
            byte_mode = i[0];
            pulse_start();
            tick(20);
            chk(16'({hold_a, link_a.busy_n}), 16'h0002);
            wait_valid();
            chk(result, codes[i]);
            wait_ready();
        end
        $display("host read test done");
        // Host abort while it waits on busy
        pulse_start();
        tick(30);
        abort = 1'b1;
        tick(30);
        abort = 1'b0;
        chk(16'({result_valid, link_a.busy_n}), 16'h0001);
        wait_ready();
        $display("host abort test done");
        // Second link: select starts, old then new data read
        drive_b(1'b1, 1'b0, 1'b0, 2);
        drive_b(1'b0, 1'b0, 1'b0, 3);
        chk(16'(link_b.db_oe), 16'h0000);
        chk(16'({hold_b, link_b.busy_n}), 16'h0002);
        drive_b(1'b0, 1'b1, 1'b0, 3);
        chk(link_b.db, 16'h0000);
        sample_b = 16'h5678;
        wait_busy_b();
        tick(2);
        chk(link_b.db, 16'h1234);
        drive_b(1'b0, 1'b1, 1'b1, 3);
        chk(link_b.db, 16'h3412);
        drive_b(1'b1, 1'b1, 1'b0, 3);
        chk(16'(link_b.db_oe), 16'h0000);
        $display("second link read test done");
        // Abort, then a restart with both lines held low
        drive_b(1'b0, 1'b0, 1'b0, 3);
        drive_b(1'b0, 1'b1, 1'b0, 2);
        drive_b(1'b0, 1'b0, 1'b0, 8);
        chk(16'({hold_b, link_b.busy_n}), 16'h0001);
        drive_b(1'b0, 1'b1, 1'b0, CYCLE_TIME_CYC);
        chk(link_b.db, 16'h1234);
        drive_b(1'b0, 1'b0, 1'b0, 2);
        // Restart must not pick up this new input
        sample_b = 16'h9abc;
        wait_busy_b();
        tick(1);
        chk(16'({hold_b, link_b.busy_n}), 16'h0002);
        drive_b(1'b0, 1'b1, 1'b0, 1);
        wait_busy_b();
        tick(2);
        chk(link_b.db, 16'h5678);
        drive_b(1'b1, 1'b1, 1'b0, 1);
        $display("second link abort test done");
        end_of_test();
    end

endmodule: sap_adc_parallel_conversion_port_test

// >>> testbench/sap_link_properties.sv
`timescale 1ns/1ps
// ----------------------------------------
// Timing properties of the converter link
// ----------------------------------------
module sap_link_check
(
    // Clock and reset
    input wire logic                       CLK,
    input wire logic                       NRST,
    // Link signals
    input wire logic                       cs_n,
    input wire logic                       rc_n,
    input wire logic                       byte_sel,
    input wire logic                       busy_n,
    input wire logic [sap_pkg::DATA_W-1:0] db_o,
    input wire logic                       db_oe
);
    import sap_pkg::*;

    // Busy-low length; saturates so a hung busy stays visible
    logic [CNT_W-1:0]  cnt_reg;
    logic [CNT_W-1:0]  cnt_next;
    wire  [DATA_W-1:0] db_swap = {db_o[BYTE_W-1:0], db_o[DATA_W-1:BYTE_W]};

    always_comb
    begin
        cnt_next = busy_n ? '0 : (cnt_reg == '1 ? cnt_reg : cnt_reg + 1'b1);
    end

    always_ff @(posedge CLK or negedge NRST)
    begin
        if (!NRST)
            cnt_reg <= '0;
        else
            cnt_reg <= cnt_next;
    end

    default clocking cb @(posedge CLK);
    endclocking
    default disable iff (!NRST);

    // Start: idle device, and the OR of both lines falls
    sequence start_seq;
        busy_n && $past(busy_n) && $fell(cs_n | rc_n);
    endsequence

    // Abort: convert seen high while busy, then low five cycles
    sequence abort_seq;
        !busy_n && rc_n ##1 (!busy_n && !rc_n) [*5];
    endsequence

    start_busy_a: assert property (start_seq |=> !busy_n)
        else $error("busy did not fall after a start");
    conv_len_a: assert property (($rose(busy_n) && $past(rc_n, 3))
        |-> cnt_reg == DONE_CNT + 1'b1)
        else $error("busy low for the wrong number of cycles");
    conv_max_a: assert property (!busy_n
        |-> int'(cnt_reg) < CONV_TIME_MAX_CYC)
        else $error("conversion ran past its longest time");
    prev_keep_a: assert property ((!busy_n && cnt_reg != '0
        && cnt_reg <= RESULT_CNT) |-> $stable(db_o))
        else $error("previous result lost too early");
    valid_before_a: assert property (($rose(busy_n) && $past(rc_n, 3))
        |-> db_o == $past(db_o, 5))
        else $error("new data not settled before busy rose");
    bus_release_a: assert property ((cs_n || !rc_n) |=> !db_oe)
        else $error("bus driven while not selected for read");
    abort_end_a: assert property (abort_seq |-> ##[1:2] busy_n)
        else $error("abort did not end the conversion");
    byte_swap_a: assert property ((busy_n && $past(busy_n)
        && $changed(byte_sel)) |=> db_o == $past(db_swap))
        else $error("byte select did not swap the halves");

endmodule: sap_link_check
